//--- rtl/dac_serial_pkg.sv
// Package with constants for the eight-channel DAC serial load logic.
`default_nettype none
package dac_serial_pkg;
   localparam int WORD_BITS = 16;
   localparam int ADDR_MSB = 15;
   localparam int ADDR_LSB = 12;
   localparam int CODE_BITS = 12;
   localparam int CHANNELS = 8;
   localparam logic [4:0] LAST_BIT_COUNT = 5'h10;
   localparam logic [3:0] ADDR_FIRST_CTRL = 4'h8;
   localparam logic [3:0] ADDR_PRESET = 4'hA;
   localparam int CHAIN_ENABLE_BIT = 3;
   localparam logic [11:0] CODE_RESET = 12'h000;
   localparam logic [11:0] MASK_10BIT = 12'hFFC;
   localparam logic [11:0] MASK_8BIT = 12'hFF0;
   typedef enum logic [1:0] {
      LINK_IDLE = 2'b00,
      LINK_SHIFT = 2'b01,
      LINK_DONE = 2'b11
   } link_state_t;
endpackage : dac_serial_pkg
`default_nettype wire

//--- rtl/dac_serial_load.sv
// Serial load logic of an eight-channel DAC: shifter, holding registers, latches, chain output.
// Notes on behaviour
// - Frame sync falling starts MSB-first shifting on each serial clock falling edge.
// - After sixteen bits the word goes to the holding register it addresses.
// - Holding values move into the DAC latches only while load is low.
// - Load is asynchronous; holding it low makes every write take effect directly.
// - Chain output repeats sampled input bits sixteen serial clocks later.
// - Reset clears every latch and register, preset register included, but sets the frame sync and load synchronisers high.
// - After reset outputs are forced to zero only when load is low.
// - Cleared registers stay zero until a valid write changes them.
// - Microcontroller mode samples the last bit on the sixteenth falling edge.
// - Codes span full 12 bits, 10 or 8 bit modes ignore unused low bits.
// - The latched code goes to the converter unmodified.
// - Word carries address in bits 15..12 and code in bits 11..0.
// - Addresses select channels, control, preset, or a pair with complemented second.
// - Microcontroller mode discards the word when frame sync rises before bit sixteen.
// - Chain output works only with its control enable bit set; off after reset.
`default_nettype none
module dac_serial_load #(
   parameter int RESOLUTION = 12
) (
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic SERIAL_CLK,
   input wire logic SERIAL_DATA,
   input wire logic FRAME_SYNC_N,
   input wire logic LOAD_OUTPUTS_N,
   input wire logic MCU_MODE,
   output logic CHAIN_OUT,
   output logic [95:0] DAC_CODES,
   output logic [11:0] PRESET_CODE,
   output logic [11:0] CONTROL_WORD,
   output logic OUTPUTS_FORCED_ZERO
);
   localparam logic [11:0] CODE_MASK = (RESOLUTION == 10) ? dac_serial_pkg::MASK_10BIT :
      (RESOLUTION == 8) ? dac_serial_pkg::MASK_8BIT : 12'hFFF;

   typedef struct packed {
      logic [2:0] clk_sync;
      logic [2:0] fs_sync;
      logic [1:0] load_sync;
      logic [1:0] data_sync;
      logic [1:0] mode_sync;
      logic [2:0] boot;
      logic mode;
      dac_serial_pkg::link_state_t state;
      logic [4:0] count;
      logic [15:0] shift;
      logic [15:0] chain;
      logic chain_out;
      logic [11:0] ctrl;
      logic [11:0] preset;
      logic [7:0][11:0] hold;
      logic [7:0][11:0] latch;
      logic forced_zero;
   } state_t;

   state_t st_reg;
   state_t st_next;
   logic clk_fall;
   logic fs_low;
   logic fs_rise;
   logic word_ok;
   logic [3:0] addr;
   logic [11:0] code;
   logic [2:0] ch;
   logic [2:0] odd_ch;
   logic boot_settle;

   assign clk_fall = st_reg.clk_sync[2] & ~st_reg.clk_sync[1];
   assign fs_low = ~st_reg.fs_sync[1];
   assign fs_rise = ~st_reg.fs_sync[2] & st_reg.fs_sync[1];
   assign addr = st_reg.shift[dac_serial_pkg::ADDR_MSB:dac_serial_pkg::ADDR_LSB];
   assign code = st_reg.shift[dac_serial_pkg::CODE_BITS-1:0] & CODE_MASK;
   assign ch = addr[2:0];
   assign odd_ch = {addr[1:0], 1'b1};
   assign boot_settle = st_reg.boot[1] & ~st_reg.boot[2];

   // In microcontroller mode the word is only committed on frame-sync rise; in DSP mode
   // it commits on the sixteenth bit.
   always_comb begin
      st_next = st_reg;
      word_ok = 1'b0;
      st_next.clk_sync = {st_reg.clk_sync[1:0], SERIAL_CLK};
      st_next.fs_sync = {st_reg.fs_sync[1:0], FRAME_SYNC_N};
      st_next.load_sync = {st_reg.load_sync[0], LOAD_OUTPUTS_N};
      // Data and mode pass two flip-flops, as the clock does up to the stage where its fall is seen, so they stay aligned to it.
      st_next.data_sync = {st_reg.data_sync[0], SERIAL_DATA};
      st_next.mode_sync = {st_reg.mode_sync[0], MCU_MODE};
      st_next.boot = {st_reg.boot[1:0], 1'b1};
      if (clk_fall) begin
         st_next.chain = {st_reg.chain[14:0], st_reg.data_sync[1]};
         st_next.chain_out = st_reg.chain[15] & st_reg.ctrl[dac_serial_pkg::CHAIN_ENABLE_BIT];
      end
      case (st_reg.state)
         dac_serial_pkg::LINK_IDLE: begin
            st_next.count = 5'h00;
            st_next.mode = st_reg.mode_sync[1];
            if (fs_low) begin
               st_next.state = dac_serial_pkg::LINK_SHIFT;
            end
         end
         dac_serial_pkg::LINK_SHIFT: begin
            if (st_reg.mode && fs_rise) begin
               st_next.state = dac_serial_pkg::LINK_IDLE;
            end else if (clk_fall) begin
               st_next.shift = {st_reg.shift[14:0], st_reg.data_sync[1]};
               st_next.count = st_reg.count + 5'h01;
               if (st_reg.count == dac_serial_pkg::LAST_BIT_COUNT - 5'h01) begin
                  st_next.state = dac_serial_pkg::LINK_DONE;
               end
            end
         end
         dac_serial_pkg::LINK_DONE: begin
            if (!st_reg.mode || fs_rise || !fs_low) begin
               word_ok = 1'b1;
               st_next.state = st_reg.mode || !fs_low ? dac_serial_pkg::LINK_IDLE :
                  dac_serial_pkg::LINK_DONE;
               if (!st_reg.mode && fs_low) begin
                  st_next.state = dac_serial_pkg::LINK_DONE;
               end
            end
         end
         default: begin
            st_next.state = dac_serial_pkg::LINK_IDLE;
         end
      endcase
      // A DSP word commits once; it then waits for frame sync high before re-arming.
      if (st_reg.state == dac_serial_pkg::LINK_DONE && !st_reg.mode && st_reg.count == 5'h1F) begin
         word_ok = 1'b0;
      end
      if (word_ok) begin
         st_next.count = 5'h1F;
         if (!addr[3]) begin
            st_next.hold[ch] = code;
         end else if (addr == dac_serial_pkg::ADDR_FIRST_CTRL) begin
            st_next.ctrl = st_reg.shift[11:0];
         end else if (addr == dac_serial_pkg::ADDR_PRESET) begin
            st_next.preset = code;
         end else if (addr[2]) begin
            st_next.hold[{addr[1:0], 1'b0}] = code;
            st_next.hold[{addr[1:0], 1'b1}] = ~code & CODE_MASK;
         end
      end
      if (!st_reg.load_sync[1]) begin
         st_next.latch = st_next.hold;
      end
      // The load level is only trusted once its synchroniser has refilled after reset.
      if (boot_settle) begin
         st_next.forced_zero = ~st_reg.load_sync[1];
      end else if (st_next.latch != st_reg.latch) begin
         st_next.forced_zero = 1'b0;
      end
      // Disabling the chain output acts at once, not only at the next serial clock fall.
      if (!st_next.ctrl[dac_serial_pkg::CHAIN_ENABLE_BIT]) begin
         st_next.chain_out = 1'b0;
      end
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         st_reg <= '0;
         st_reg.fs_sync <= 3'h7;
         st_reg.load_sync <= 2'h3;
      end else begin
         st_reg <= st_next;
      end
   end

   assign OUTPUTS_FORCED_ZERO = st_reg.forced_zero;
   assign CHAIN_OUT = st_reg.chain_out;
   assign PRESET_CODE = st_reg.preset;
   assign CONTROL_WORD = st_reg.ctrl;

   // Channel A sits in the lowest twelve bits of the flat code bus.
   for (genvar g = 0; g < dac_serial_pkg::CHANNELS; g++) begin : g_code
      assign DAC_CODES[g * dac_serial_pkg::CODE_BITS +: dac_serial_pkg::CODE_BITS] =
         st_reg.latch[g];
   end

   // A committed channel, pair or preset word is judged one clock later against a register that it addressed; control words are not.
   sequence s_commit;
      st_reg.state == dac_serial_pkg::LINK_DONE && word_ok;
   endsequence

   sequence s_channel_word;
      s_commit ##0 !addr[3];
   endsequence

   sequence s_pair_word;
      s_commit ##0 (addr[3] && addr[2]);
   endsequence

   a_chain_off: assert property (@(posedge MCLK) disable iff (!RSTN)
      !st_reg.ctrl[dac_serial_pkg::CHAIN_ENABLE_BIT] |-> !CHAIN_OUT)
      else $error("chain output active while disabled");
   a_latch_hold: assert property (@(posedge MCLK) disable iff (!RSTN)
      st_reg.load_sync[1] |=> $stable(st_reg.latch))
      else $error("latches changed while load high");
   a_count_max: assert property (@(posedge MCLK) disable iff (!RSTN)
      st_reg.state == dac_serial_pkg::LINK_SHIFT |-> st_reg.count < 5'h10)
      else $error("bit count overran");
   a_mcu_cancel: assert property (@(posedge MCLK) disable iff (!RSTN)
      st_reg.mode && fs_rise && st_reg.state == dac_serial_pkg::LINK_SHIFT
      |=> st_reg.state == dac_serial_pkg::LINK_IDLE && $stable(st_reg.hold))
      else $error("short microcontroller frame not discarded");
   a_word_store: assert property (@(posedge MCLK) disable iff (!RSTN)
      s_channel_word |=> st_reg.hold[$past(ch)] == $past(code))
      else $error("channel word not stored in its holding register");
   a_pair_store: assert property (@(posedge MCLK) disable iff (!RSTN)
      s_pair_word |=> st_reg.hold[$past(odd_ch)] == (~$past(code) & CODE_MASK))
      else $error("pair word did not store the complement");
   a_preset_store: assert property (@(posedge MCLK) disable iff (!RSTN)
      s_commit ##0 (addr == dac_serial_pkg::ADDR_PRESET) |=> PRESET_CODE == $past(code))
      else $error("preset word not stored");
   a_zero_hold: assert property (@(posedge MCLK) disable iff (!RSTN)
      OUTPUTS_FORCED_ZERO |-> st_reg.latch == '0)
      else $error("outputs flagged forced zero with a nonzero latch");
endmodule : dac_serial_load
`default_nettype wire

//--- verification/dac_host_model.sv
// Host serial port model that shifts words into the DAC.
`default_nettype none
module dac_host_model (
   input wire logic mclk,
   output var logic serial_clk,
   output var logic serial_data,
   output var logic frame_sync_n
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      serial_clk = 1'b0;
      serial_data = 1'b0;
      frame_sync_n = 1'b1;
   end
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
   endtask : step
   // The clock stands low between frames, and idle data shows the inverse of the last bit.
   task automatic send(input logic [15:0] w, input int n, input logic dsp);
      step(1);
      if (dsp) begin
         serial_clk <= 1'b1;
         step(4);
         serial_clk <= 1'b0;
         step(4);
      end
      frame_sync_n <= 1'b0;
      step(4);
      for (int i = 0; i < n; i++) begin
         serial_clk <= 1'b1;
         serial_data <= w[15 - i];
         step(4);
         serial_clk <= 1'b0;
         step(4);
      end
      frame_sync_n <= 1'b1;
      serial_data <= ~serial_data;
      step(8);
   endtask : send
endmodule : dac_host_model
`default_nettype wire

//--- verification/dac_serial_load_tb.sv
// Self-checking bench for the DAC serial load logic.
`default_nettype none
module dac_serial_load_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic load_n = 1'b0;
   logic mcu_mode = 1'b1;
   wire logic sclk, sdata, fsn, chain, zero;
   wire logic [95:0] codes;
   wire logic [11:0] preset, ctrl;
   int bad_count = 0;
   int checks_done = 0;
   initial forever #20 mclk = ~mclk;
   dac_host_model i_dac_host_model (.mclk(mclk), .serial_clk(sclk), .serial_data(sdata),
      .frame_sync_n(fsn));
   dac_serial_load i_dac_serial_load (.MCLK(mclk), .RSTN(rstn), .SERIAL_CLK(sclk),
      .SERIAL_DATA(sdata), .FRAME_SYNC_N(fsn), .LOAD_OUTPUTS_N(load_n), .MCU_MODE(mcu_mode),
      .CHAIN_OUT(chain), .DAC_CODES(codes), .PRESET_CODE(preset), .CONTROL_WORD(ctrl),
      .OUTPUTS_FORCED_ZERO(zero));
   task automatic stop_test;
      if (bad_count == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [11:0] ch(input int n);
      return codes[n * 12 +: 12];
   endfunction : ch
   task automatic put(input logic [3:0] a, input logic [11:0] d);
      i_dac_host_model.send({a, d}, 16, !mcu_mode);
      @(negedge mclk);
   endtask : put
   task automatic t_reset;
      for (int i = 0; i < 8; i++) chk(ch(i), 12'h000);
      chk(preset, 12'h000);
      chk(ctrl, 12'h000);
      chk({11'h000, chain}, 12'h000);
      chk({11'h000, zero}, 12'h001);
   endtask : t_reset
   task automatic t_channels;
      for (int i = 0; i < 8; i++) begin
         chk(ch(i), 12'h000);
         put(i[3:0], 12'hA50 ^ i[11:0]);
         chk(ch(i), 12'hA50 ^ i[11:0]);
      end
      chk({11'h000, zero}, 12'h000);
   endtask : t_channels
   task automatic t_hold;
      @(posedge mclk) load_n <= 1'b1;
      put(4'h0, 12'h5A5);
      chk(ch(0), 12'hA50);
      @(posedge mclk) load_n <= 1'b0;
      repeat (8) @(negedge mclk);
      chk(ch(0), 12'h5A5);
   endtask : t_hold
   task automatic t_abort;
      i_dac_host_model.send(16'h3FFF, 8, 1'b0);
      @(negedge mclk);
      chk(ch(3), 12'hA53);
   endtask : t_abort
   task automatic t_regs;
      put(4'hA, 12'h7E1);
      put(4'h9, 12'hFFF);
      put(4'hB, 12'hFFF);
      chk(preset, 12'h7E1);
      chk(ctrl, 12'h000);
      put(4'h8, 12'h008);
      chk(ctrl, 12'h008);
   endtask : t_regs
   // Sampling waits six cycles after each fall so the synchroniser delay has passed.
   task automatic t_chain;
      logic [15:0] w;
      w = 16'h00C3;
      put(4'h0, w[11:0]);
      fork
         put(4'h1, 12'h000);
         for (int k = 0; k < 16; k++) begin
            @(negedge sclk);
            repeat (6) @(posedge mclk);
            #1 chk({11'h000, chain}, {11'h000, w[15 - k]});
         end
      join
   endtask : t_chain
   task automatic t_pair;
      for (int p = 0; p < 4; p++) begin
         put(4'hC + p[3:0], 12'h3C1 + p[11:0]);
         chk(ch(2 * p), 12'h3C1 + p[11:0]);
         chk(ch(2 * p + 1), ~(12'h3C1 + p[11:0]));
      end
   endtask : t_pair
   task automatic t_dsp;
      @(posedge mclk) mcu_mode <= 1'b0;
      @(posedge mclk);
      put(4'h5, 12'h0F0);
      chk(ch(5), 12'h0F0);
   endtask : t_dsp
   // A second power-up with load high must leave the outputs unforced.
   task automatic t_reboot;
      @(posedge mclk) begin
         rstn <= 1'b0;
         load_n <= 1'b1;
      end
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      repeat (4) @(negedge mclk);
      chk({11'h000, zero}, 12'h000);
      chk(ch(5), 12'h000);
      chk(preset, 12'h000);
      chk(ctrl, 12'h000);
      chk({11'h000, chain}, 12'h000);
      @(posedge mclk) load_n <= 1'b0;
      repeat (4) @(negedge mclk);
      chk({11'h000, zero}, 12'h000);
      put(4'h2, 12'h123);
      chk(ch(2), 12'h123);
   endtask : t_reboot
   initial begin
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      repeat (4) @(negedge mclk);
      t_reset;
      t_channels;
      t_hold;
      t_abort;
      t_regs;
      t_chain;
      t_pair;
      t_dsp;
      t_reboot;
      stop_test;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      bad_count++;
      stop_test;
   end
endmodule : dac_serial_load_tb
`default_nettype wire
